/* cpt_pkg.sv */
// Constants, field positions and state carrier of the compact timer.
package cpt_pkg;

  // ----------------------------------------
  // Register map (word index, byte address = index * 4)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [2:0] IDX_C0   = 3'h0;
  localparam logic [2:0] IDX_C1   = 3'h1;
  localparam logic [2:0] IDX_CNTL = 3'h2;
  localparam logic [2:0] IDX_CNTH = 3'h3;
  localparam logic [2:0] IDX_AL   = 3'h4;
  localparam logic [2:0] IDX_AH   = 3'h5;
  localparam logic [2:0] IDX_P    = 3'h6;
  localparam logic [2:0] IDX_ST   = 3'h7;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_PAU = 7;
  localparam int B_CKH = 6;
  localparam int B_CKL = 4;
  localparam int B_ON  = 3;
  localparam int B_MDH = 7;
  localparam int B_MDL = 6;
  localparam int B_IOH = 5;
  localparam int B_IOL = 4;
  localparam int B_OC  = 3;
  localparam int B_POL = 2;
  localparam int B_DPX = 1;
  localparam int B_CCL = 0;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] MD_CMO  = 2'h0;
  localparam logic [1:0] MD_PWM  = 2'h2;
  localparam logic [1:0] MD_TC   = 2'h3;
  localparam logic [1:0] IO_LOW  = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TGL  = 2'h3;
  localparam logic [1:0] IO_ACT  = 2'h1;
  localparam logic [1:0] IO_PWM  = 2'h2;
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS  = 3'h1;
  localparam logic [2:0] CK_H16  = 3'h2;
  localparam logic [2:0] CK_H64  = 3'h3;
  localparam logic [2:0] CK_EXTR = 3'h6;
  localparam logic [2:0] CK_EXTF = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] C0_WMASK    = 8'hF8;
  localparam logic [7:0] RST_BYTE    = 8'h00;

  typedef struct packed {
    logic [7:0]  c0;
    logic [7:0]  c1;
    logic [7:0]  cmp_p;
    logic [7:0]  bufr;
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [1:0]  flag;
    logic        on_d;
    logic        lvl;
    logic        pin;
    logic [1:0]  pre;
    logic [5:0]  hdiv;
    logic [2:0]  ext;
    logic        aw_h;
    logic [ADDR_W-1:0] aw_a;
    logic        w_h;
    logic [7:0]  w_d;
    logic        w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
  } cpt_state_t;

  localparam cpt_state_t ST_RST = '0;

endpackage

/* cpt_timer.sv */
// Compact timer with AXI4-Lite register access.
// Notes on behaviour
// - A 16-bit up-counter advances on the selected clock source.
// - Comparator P checks counter high byte; comparator A checks all sixteen bits.
// - Software cannot write the counter; software clears it only through an on-bit rise.
// - Counter clears on overflow or selected match, raising a request flag.
// - Pause bit holds the counter; clearing it resumes from the held value.
// - Clock select: sys/4, sys, high/16, high/64, sub, sub, pin rise, pin fall.
// - On bit low stops and keeps count; rising edge zeroes and starts counting.
// - On-bit rise returns the pin to its initial level in compare and PWM.
// - Low three bits of control zero always read as zero.
// - Mode field: compare output, undefined, PWM, timer/counter.
// - Compare mode A match: no change, drive low, drive high, toggle.
// - PWM mode output field: inactive, active, waveform, undefined.
// - A match asking for the level already present shows no change.
// - Output control bit sets initial level or PWM active level.
// - Polarity bit inverts the pin in compare and PWM modes only.
// - Swap bit exchanges period and duty roles of the compare registers.
// - Clear select picks A match or P match/overflow; ignored in PWM.
// - Counter reads as read-only low and high bytes, reset to zero.
// - Low bytes pass through one byte buffer tied to high-byte accesses.
// - Period value zero means 65536 clocks, else 256 times the value.
// - PWM duty not below the period gives a constant active output.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cpt_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // Timer clock sources and pins
  input  wire logic        high_clock_tick,
  input  wire logic        sub_clock_tick,
  input  wire logic        external_clock_pin,
  output      logic        timer_output_pin
);

  cpt_pkg::cpt_state_t s;
  cpt_pkg::cpt_state_t next_s;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic sel_tick(input logic [2:0] sel, input logic [1:0] pre,
                                    input logic [5:0] hd, input logic ht, input logic st,
                                    input logic er, input logic ef);
    case (sel)
      cpt_pkg::CK_SYS4: return &pre;
      cpt_pkg::CK_SYS:  return 1'b1;
      cpt_pkg::CK_H16:  return ht & (&hd[3:0]);
      cpt_pkg::CK_H64:  return ht & (&hd);
      cpt_pkg::CK_EXTR: return er;
      cpt_pkg::CK_EXTF: return ef;
      default:          return st;
    endcase
  endfunction

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  logic        on;
  logic        pause;
  logic [2:0]  csel;
  logic [1:0]  mode;
  logic [1:0]  iof;
  logic        oc;
  logic        pol;
  logic        dpx;
  logic        ccl;
  logic        rise_on;
  logic        run;
  logic        ext_r;
  logic        ext_f;
  logic        tick;
  logic        adv;
  logic [16:0] n;
  logic        hit_a;
  logic        hit_p;
  logic        clr;
  logic        ev_a;
  logic        ev_p;
  logic [16:0] pwide;
  logic [16:0] duty;
  logic        act;
  logic        have_aw;
  logic        have_w;
  logic        do_wr;
  logic [7:0]  wa;
  logic [7:0]  wd;
  logic        ws;
  logic        do_rd;
  logic [1:0]  clr_f;

  assign on      = s.c0[cpt_pkg::B_ON];
  assign pause   = s.c0[cpt_pkg::B_PAU];
  assign csel    = s.c0[cpt_pkg::B_CKH:cpt_pkg::B_CKL];
  assign mode    = s.c1[cpt_pkg::B_MDH:cpt_pkg::B_MDL];
  assign iof     = s.c1[cpt_pkg::B_IOH:cpt_pkg::B_IOL];
  assign oc      = s.c1[cpt_pkg::B_OC];
  assign pol     = s.c1[cpt_pkg::B_POL];
  assign dpx     = s.c1[cpt_pkg::B_DPX];
  assign ccl     = s.c1[cpt_pkg::B_CCL];
  assign rise_on = on & ~s.on_d;
  assign run     = on & s.on_d;

  // ----------------------------------------
  // Counter clocking and compare
  // ----------------------------------------
  // Edge detection looks only at the second and third sync stages.
  assign ext_r = s.ext[1] & ~s.ext[2];
  assign ext_f = ~s.ext[1] & s.ext[2];
  assign tick  = sel_tick(csel, s.pre, s.hdiv, high_clock_tick, sub_clock_tick, ext_r, ext_f);
  assign adv   = run & ~pause & tick;
  assign n     = {1'b0, s.cnt} + 17'h00001;

  // A period value of zero lets the counter run to overflow.
  assign hit_p = (s.cmp_p == 8'h00) ? n[16] : (n[15:0] == {s.cmp_p, 8'h00});
  assign hit_a = (s.cmp_a != 16'h0000) && (n[15:0] == s.cmp_a);

  always_comb begin
    if (mode == cpt_pkg::MD_PWM) begin
      clr = dpx ? hit_a : hit_p;
    end else begin
      clr = ccl ? hit_a : hit_p;
    end
  end

  assign ev_a = adv & hit_a;
  assign ev_p = adv & hit_p & ~(ccl & (mode != cpt_pkg::MD_PWM));

  // ----------------------------------------
  // PWM duty
  // ----------------------------------------
  assign pwide = (s.cmp_p == 8'h00) ? 17'h10000 : {1'b0, s.cmp_p, 8'h00};
  assign duty  = dpx ? pwide : {1'b0, s.cmp_a};
  // Counter never reaches the period, so a duty at or above it stays active.
  assign act   = ({1'b0, s.cnt} < duty);

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  assign awready = ~s.aw_h & ~s.bvalid;
  assign wready  = ~s.w_h & ~s.bvalid;
  assign arready = ~s.rvalid;
  assign have_aw = s.aw_h | (awvalid & awready);
  assign have_w  = s.w_h | (wvalid & wready);
  assign do_wr   = have_aw & have_w;
  assign wa      = s.aw_h ? s.aw_a : awaddr;
  assign wd      = s.w_h ? s.w_d : wdata[7:0];
  assign ws      = s.w_h ? s.w_s : wstrb[0];
  assign do_rd   = arvalid & arready;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    clr_f = 2'h0;
    next_s.on_d = on;
    next_s.pre = s.pre + 2'h1;
    if (high_clock_tick) begin
      next_s.hdiv = s.hdiv + 6'h01;
    end
    next_s.ext = {s.ext[1:0], external_clock_pin};

    // Counter and output level.
    if (rise_on) begin
      next_s.cnt = 16'h0000;
      if (mode != cpt_pkg::MD_TC) begin
        next_s.lvl = oc;
      end
    end else if (adv) begin
      next_s.cnt = clr ? 16'h0000 : n[15:0];
      if ((mode == cpt_pkg::MD_CMO) && ev_a) begin
        case (iof)
          cpt_pkg::IO_LOW:  next_s.lvl = 1'b0;
          cpt_pkg::IO_HIGH: next_s.lvl = 1'b1;
          cpt_pkg::IO_TGL:  next_s.lvl = ~s.lvl;
          default:          next_s.lvl = s.lvl;
        endcase
      end
    end

    // Pin level, registered.
    case (mode)
      cpt_pkg::MD_CMO: next_s.pin = s.lvl ^ pol;
      cpt_pkg::MD_PWM: begin
        case (iof)
          cpt_pkg::IO_ACT: next_s.pin = oc ^ pol;
          cpt_pkg::IO_PWM: next_s.pin = (act ? oc : ~oc) ^ pol;
          default:         next_s.pin = ~oc ^ pol;
        endcase
      end
      default: next_s.pin = s.lvl;
    endcase

    // Read channel, with the buffer latch on high-byte reads.
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (do_rd) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = cpt_pkg::RESP_OKAY;
      next_s.rdata = 8'h00;
      if (!is_mapped(araddr)) begin
        next_s.rresp = cpt_pkg::RESP_SLVERR;
      end else begin
        case (araddr[4:2])
          cpt_pkg::IDX_C0:   next_s.rdata = s.c0 & cpt_pkg::C0_WMASK;
          cpt_pkg::IDX_C1:   next_s.rdata = s.c1;
          cpt_pkg::IDX_CNTL: next_s.rdata = s.bufr;
          cpt_pkg::IDX_CNTH: begin
            next_s.rdata = s.cnt[15:8];
            next_s.bufr = s.cnt[7:0];
          end
          cpt_pkg::IDX_AL:   next_s.rdata = s.bufr;
          cpt_pkg::IDX_AH: begin
            next_s.rdata = s.cmp_a[15:8];
            next_s.bufr = s.cmp_a[7:0];
          end
          cpt_pkg::IDX_P:    next_s.rdata = s.cmp_p;
          default:           next_s.rdata = {6'h00, s.flag};
        endcase
      end
    end

    // Write channel; a write to the buffer wins over a same-cycle latch.
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_h = 1'b0;
      next_s.w_h = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(wa) ? cpt_pkg::RESP_OKAY : cpt_pkg::RESP_SLVERR;
      if (is_mapped(wa) && ws) begin
        case (wa[4:2])
          cpt_pkg::IDX_C0: next_s.c0 = wd & cpt_pkg::C0_WMASK;
          cpt_pkg::IDX_C1: next_s.c1 = wd;
          cpt_pkg::IDX_AL: next_s.bufr = wd;
          cpt_pkg::IDX_AH: next_s.cmp_a = {wd, s.bufr};
          cpt_pkg::IDX_P:  next_s.cmp_p = wd;
          cpt_pkg::IDX_ST: clr_f = wd[1:0];
          default:         next_s.cnt = next_s.cnt;
        endcase
      end
    end else begin
      if (awvalid && awready) begin
        next_s.aw_h = 1'b1;
        next_s.aw_a = awaddr;
      end
      if (wvalid && wready) begin
        next_s.w_h = 1'b1;
        next_s.w_d = wdata[7:0];
        next_s.w_s = wstrb[0];
      end
    end

    // A new match wins over a clear in the same cycle.
    next_s.flag = (s.flag & ~clr_f) | {ev_p, ev_a};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= cpt_pkg::ST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign bvalid           = s.bvalid;
  assign bresp            = s.bresp;
  assign rvalid           = s.rvalid;
  assign rresp            = s.rresp;
  assign rdata            = {24'h000000, s.rdata};
  assign timer_output_pin = s.pin;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_on_rise;
    on && !s.on_d;
  endsequence

  sequence s_holding;
    on && s.on_d && pause;
  endsequence

  a_start_clear: assert property (s_on_rise |=> s.cnt == 16'h0000)
    else $error("counter not zero after on-bit rise");
  a_pause_hold: assert property (s_holding |=> $stable(s.cnt))
    else $error("counter moved while paused");
  a_off_hold: assert property (!on |=> s.cnt == $past(s.cnt))
    else $error("counter moved while off");
  a_init_level: assert property ((s_on_rise and (mode != cpt_pkg::MD_TC)) |=> s.lvl == $past(oc))
    else $error("initial level not restored");
  a_flag_a_set: assert property (ev_a |=> s.flag[0])
    else $error("match A flag lost");
  a_flag_p_set: assert property (ev_p |=> s.flag[1])
    else $error("match P flag lost");
  a_no_p_flag: assert property (adv && ccl && mode != cpt_pkg::MD_PWM |=> !$rose(s.flag[1]))
    else $error("P flag raised with A clear");
  a_cmp_high: assert property (ev_a && !rise_on && mode == cpt_pkg::MD_CMO && iof == cpt_pkg::IO_HIGH
                               |=> s.lvl ##1 timer_output_pin == !pol)
    else $error("compare high not driven");
  a_cmp_low: assert property (ev_a && !rise_on && mode == cpt_pkg::MD_CMO && iof == cpt_pkg::IO_LOW |=> !s.lvl)
    else $error("compare low not driven");
  a_clear_sel: assert property (adv && clr && !rise_on |=> s.cnt == 16'h0000)
    else $error("counter not cleared on match");
  a_ext_edge: assert property (run && csel == cpt_pkg::CK_EXTR && !ext_r && !rise_on |=> $stable(s.cnt))
    else $error("counter moved without pin edge");
  a_pwm_full: assert property (mode == cpt_pkg::MD_PWM && iof == cpt_pkg::IO_PWM && duty > {1'b0, s.cnt}
                               |=> timer_output_pin == $past(oc ^ pol))
    else $error("PWM not active below duty");
  a_buf_commit: assert property (do_wr && ws && is_mapped(wa) && wa[4:2] == cpt_pkg::IDX_AH
                                 |=> s.cmp_a[7:0] == $past(s.bufr))
    else $error("buffered low byte not committed");

endmodule

/* test_cpt_timer.sv */
// Self-checking testbench of the compact timer.
`timescale 1ns/1ps
module test_cpt_timer;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, hck, sck, ext_pin, pin;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rr;
  logic [15:0] v, v1, v2;
  int          fail_count, checks, cyc, n;
  int          rate [6] = '{64, 256, 8, 2, 85, 85};
  localparam logic [7:0] A_C0 = {3'h0, cpt_pkg::IDX_C0, 2'h0};
  localparam logic [7:0] A_C1 = {3'h0, cpt_pkg::IDX_C1, 2'h0};
  localparam logic [7:0] A_CL = {3'h0, cpt_pkg::IDX_CNTL, 2'h0};
  localparam logic [7:0] A_CH = {3'h0, cpt_pkg::IDX_CNTH, 2'h0};
  localparam logic [7:0] A_AL = {3'h0, cpt_pkg::IDX_AL, 2'h0};
  localparam logic [7:0] A_AH = {3'h0, cpt_pkg::IDX_AH, 2'h0};
  localparam logic [7:0] A_P  = {3'h0, cpt_pkg::IDX_P, 2'h0};
  localparam logic [7:0] A_ST = {3'h0, cpt_pkg::IDX_ST, 2'h0};
  localparam logic [2:0] SYS  = cpt_pkg::CK_SYS;

  cpt_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .high_clock_tick(hck), .sub_clock_tick(sck),
    .external_clock_pin(ext_pin), .timer_output_pin(pin)
  );

  always #2.5 aclk = ~aclk;

  // The high clock ticks every second cycle, the sub clock every third.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    hck <= (cyc % 2 == 0);
    sck <= (cyc % 3 == 0);
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [7:0] c0v(input logic [2:0] s, input logic on);
    return {1'b0, s, on, 3'h0};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ak, wk;
    ak = 1'b0;
    wk = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ak && wk)) begin
      @(posedge aclk);
      if (!ak && awready === 1'b1) begin
        ak = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wk && wready === 1'b1) begin
        wk = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rr = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
  endtask

  task automatic rd_cnt(output logic [15:0] c);
    rd(A_CH);
    c[15:8] = rv[7:0];
    rd(A_CL);
    c[7:0] = rv[7:0];
  endtask

  task automatic highs(input int cnt, output int h);
    h = 0;
    repeat (cnt) begin
      @(posedge aclk);
      if (pin === 1'b1) h++;
    end
  endtask

  task automatic pulses(input int cnt);
    repeat (cnt) begin
      ext_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      ext_pin <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rd({3'h0, i[2:0], 2'h0});
      check(rv, 32'h0);
    end
    rd(8'h22);
    check(rr, cpt_pkg::RESP_SLVERR);
    check(rv, 32'h0);
    wr(8'h40, 8'h01);
    check(rr, cpt_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(A_C0, 8'hF7);
    rd(A_C0);
    check(rv, 32'hF0);
    wr(A_C0, 8'h00);
    wr(A_CL, 8'h66);
    wr(A_CH, 8'h55);
    check(rr, cpt_pkg::RESP_OKAY);
    rd_cnt(v);
    check(v, 16'h0000);
    wr(A_AL, 8'h34);
    wr(A_AH, 8'h12);
    wr(A_AL, 8'h99);
    rd(A_AH);
    check(rv, 32'h12);
    rd(A_AL);
    check(rv, 32'h34);
    $display("test registers done");
  endtask

  task automatic t_clk;
    for (int s = 0; s < 6; s++) begin
      wr(A_C0, c0v(s[2:0], 1'b1));
      repeat (256) @(posedge aclk);
      wr(A_C0, c0v(s[2:0], 1'b0));
      rd_cnt(v);
      check(v + 1 >= rate[s] && v <= rate[s] + 3, 1'b1);
    end
    $display("test clock select done");
  endtask

  task automatic t_run;
    logic [15:0] v3;
    wr(A_C0, c0v(SYS, 1'b1));
    repeat (20) @(posedge aclk);
    wr(A_C0, {1'b1, SYS, 1'b1, 3'h0});
    rd_cnt(v1);
    repeat (10) @(posedge aclk);
    rd_cnt(v2);
    check(v2, v1);
    wr(A_C0, c0v(SYS, 1'b1));
    rd_cnt(v3);
    check(v3 > v1 && v3 < v1 + 16, 1'b1);
    wr(A_C0, c0v(SYS, 1'b0));
    rd_cnt(v1);
    repeat (10) @(posedge aclk);
    rd_cnt(v2);
    check(v2, v1);
    wr(A_C0, c0v(SYS, 1'b1));
    rd_cnt(v3);
    check(v3 < 16, 1'b1);
    $display("test pause and on done");
  endtask

  task automatic t_clear;
    logic big;
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_C1, {cpt_pkg::MD_TC, 6'h01});
    wr(A_P, 8'h01);
    wr(A_AL, 8'h10);
    wr(A_AH, 8'h01);
    wr(A_ST, 8'h03);
    wr(A_C0, c0v(SYS, 1'b1));
    repeat (300) @(posedge aclk);
    rd(A_ST);
    check(rv, 32'h1);
    rd_cnt(v);
    check(v < 16'h0110, 1'b1);
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_ST, 8'h03);
    rd(A_ST);
    check(rv, 32'h0);
    wr(A_C1, {cpt_pkg::MD_TC, 6'h00});
    wr(A_AL, 8'h10);
    wr(A_AH, 8'h00);
    wr(A_C0, c0v(SYS, 1'b1));
    repeat (300) @(posedge aclk);
    rd(A_ST);
    check(rv, 32'h3);
    big = 1'b0;
    repeat (8) begin
      rd_cnt(v);
      check(v < 256, 1'b1);
      if (v >= 16) big = 1'b1;
    end
    check(big, 1'b1);
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_P, 8'h00);
    $display("test counter clear done");
  endtask

  task automatic t_pin;
    logic [5:0] tab [5];
    logic       prev;
    tab = '{{cpt_pkg::IO_LOW, 4'b1010}, {cpt_pkg::IO_HIGH, 4'b0001},
            {cpt_pkg::IO_HIGH, 4'b1011}, {2'h0, 4'b1011}, {cpt_pkg::IO_HIGH, 4'b0110}};
    for (int i = 0; i < 5; i++) begin
      wr(A_C0, c0v(SYS, 1'b0));
      wr(A_C1, {cpt_pkg::MD_CMO, tab[i][5:2], 2'b01});
      wr(A_C0, c0v(SYS, 1'b1));
      repeat (2) @(posedge aclk);
      check(pin, tab[i][1]);
      repeat (30) @(posedge aclk);
      check(pin, tab[i][0]);
    end
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_C1, {cpt_pkg::MD_CMO, cpt_pkg::IO_TGL, 4'b0001});
    wr(A_C0, c0v(SYS, 1'b1));
    repeat (10) @(posedge aclk);
    prev = pin;
    n = 0;
    repeat (64) begin
      @(posedge aclk);
      if (pin !== prev) n++;
      prev = pin;
    end
    check(n, 4);
    $display("test output pin done");
  endtask

  task automatic t_ext;
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_C1, 8'h00);
    wr(A_C0, c0v(cpt_pkg::CK_EXTR, 1'b1));
    pulses(5);
    rd_cnt(v);
    check(v, 16'h0005);
    wr(A_C0, c0v(cpt_pkg::CK_EXTR, 1'b0));
    wr(A_C0, c0v(cpt_pkg::CK_EXTF, 1'b1));
    pulses(3);
    rd_cnt(v);
    check(v, 16'h0003);
    $display("test external clock done");
  endtask

  task automatic t_pwm;
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_P, 8'h01);
    wr(A_AL, 8'h40);
    wr(A_AH, 8'h00);
    wr(A_C1, {cpt_pkg::MD_PWM, cpt_pkg::IO_PWM, 4'b1000});
    wr(A_C0, c0v(SYS, 1'b1));
    repeat (20) @(posedge aclk);
    highs(256, n);
    check(n, 64);
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_C1, {cpt_pkg::MD_PWM, cpt_pkg::IO_PWM, 4'b1010});
    wr(A_C0, c0v(SYS, 1'b1));
    repeat (20) @(posedge aclk);
    highs(64, n);
    check(n, 64);
    wr(A_C0, c0v(SYS, 1'b0));
    wr(A_C1, {cpt_pkg::MD_PWM, cpt_pkg::IO_ACT, 4'b1100});
    repeat (4) @(posedge aclk);
    check(pin, 1'b0);
    wr(A_C1, {cpt_pkg::MD_PWM, 2'h0, 4'b0000});
    repeat (4) @(posedge aclk);
    check(pin, 1'b1);
    $display("test pwm done");
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    stop_test;
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, ext_pin} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = '0;
    {fail_count, checks} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_regs;
    t_clk;
    t_run;
    t_clear;
    t_pin;
    t_ext;
    t_pwm;
    stop_test;
  end
endmodule
